// >>> analog_env_model.sv
// regulator comparators and vco range flag seen by the control block
`timescale 1ns/1ns
module analog_env_model (
  input wire logic aclk,
  input wire logic regulator_on,
  input wire logic brown,
  input wire logic vco_ok,
  output prcc_pkg::regulator_status_reg_level_type regulator_status_reg_level,
  output logic vco_in_range
);
  import prcc_pkg::*;
  // regulated output needs a few cycles to climb past 2.3 V
  logic [2:0] ramp_r = 3'h0;
  always_ff @(posedge aclk) begin
    ramp_r <= {ramp_r[1:0], regulator_on};
  end
  // power-down level sits above 1.3 V; brown-out pulls both below
  // one driver for the whole struct: {above_2v3, above_1v3}
  assign regulator_status_reg_level = {ramp_r[2] & ~brown, ~brown};
  assign vco_in_range = vco_ok;
endmodule

// >>> power_reset_clock_control.sv
// power, reset, oscillator, clock output and synthesizer control
// Operation
// - clock out is reference over 1..2048
// - ratios above one give 50% duty
// - four-bit pin config field picks ratio
// - a bit disables the clock output
// - toggling power-mode reset bit resets all but the bus and power-on state
// - low pulse on reset pin resets device
// - every reset restores register defaults
// - reset pin ignored until power-on done
// - regulator starts powered down
// - rx or tx mode powers regulator first
// - live regulator 1.3 V and 2.3 V flags
// - sticky copies catch brown-out events
// - oscillator off until power mode enables
// - four-bit oscillator transconductance field
// - six-bit crystal tuning capacitance field
// - carrier frequency set in 1 Hz steps
// - receiver shifts synthesizer by IF automatically
// - all settings reached through the slave port
// - start bit launches automatic VCO ranging
// - start bit clears at end, error reported
`timescale 1ns/1ns
module power_reset_clock_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [prcc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [prcc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic reset_pin_n,
  input wire prcc_pkg::regulator_status_reg_level_type regulator_status_reg_level,
  input wire logic vco_in_range,
  output logic divided_ref_clock_out,
  output logic regulator_on,
  output logic osc_enable,
  output logic rx_enable,
  output logic tx_enable,
  output logic ranging_active,
  output logic [31:0] synth_carrier_regs_a_hz,
  output logic [3:0] osc_transconductance,
  output logic [5:0] osc_tuning_cap,
  output logic band_select_bit,
  output logic [3:0] synth_loop_bits
);
  import prcc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] por_cnt_r;
  logic por_done_r, soft_rst_r, pin_rst, clr;
  power_mode_type pm_mode_r;
  logic pm_rst_r;
  logic [3:0] gm_r;
  logic [5:0] cap_r;
  logic [7:0] pin_cfg_r;
  logic [31:0] carrier_regs_a_r, if_r;
  logic [4:0] loop_r;
  logic [1:0] sticky_r, vprev_r;
  logic ranging_start_bit_r, rng_err_r;
  logic [15:0] rng_cnt_r;
  logic [9:0] div_cnt_r;
  logic [3:0] sel_prev_r;
  logic div_out_r, ratio_one_r, clk_en, sel_change;
  logic [9:0] div_last;
  op_state_type op_r, op_nxt;
  logic regulator_on_r, osc_enable_r, rx_enable_r, tx_enable_r;
  logic [31:0] synth_carrier_regs_a_r;
  logic aw_v_r, w_v_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [7:0] aw_a_r;
  logic [31:0] w_d_r, rdata_r, wm;
  logic [3:0] w_s_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, rx_sel, tx_sel;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // one decode serves both the read path and the write merge
  function automatic logic [32:0] word_at(input logic [7:0] a);
    logic [32:0] w;
    w = {1'b1, 32'h0000_0000};
    if (a == ADDR_PWR) begin
      w[7:0] = {pm_rst_r, 5'h00, pm_mode_r};
    end else if (a == ADDR_REGULATOR_STATUS_REG) begin
      w[3:0] = {sticky_r, regulator_status_reg_level};
    end else if (a == ADDR_OSC) begin
      w[3:0] = gm_r;
    end else if (a == ADDR_CAP) begin
      w[5:0] = cap_r;
    end else if (a == ADDR_PIN) begin
      w[7:0] = pin_cfg_r;
    end else if (a == ADDR_CARRIER_REGS_A) begin
      w[31:0] = carrier_regs_a_r;
    end else if (a == ADDR_IF) begin
      w[31:0] = if_r;
    end else if (a == ADDR_LOOP) begin
      w[4:0] = loop_r;
    end else if (a == ADDR_RNG) begin
      w[5:4] = {rng_err_r, ranging_start_bit_r};
    end else begin
      w[32] = 1'b0;
    end
    return w;
  endfunction

  // ****************************************************************
  // power-on and reset sources
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_r <= 16'h0000;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      if (por_cnt_r == POR_LAST) begin
        por_done_r <= 1'b1;
      end else begin
        por_cnt_r <= por_cnt_r + 16'h0001;
      end
    end
  end

  // pin is dead until power-on completes; release is its rising edge
  assign pin_rst = por_done_r & ~reset_pin_n;
  assign clr = ~aresetn | soft_rst_r | pin_rst;
  assign wr_fire = aw_v_r & w_v_r & ~bvalid_r;
  assign wm = merge(32'(word_at(aw_a_r)), w_d_r, w_s_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_fire && aw_a_r == ADDR_PWR && pm_rst_r &&
                    !wm[PM_RST_BIT] && !clr;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (clr) begin
      pm_mode_r <= PM_DOWN;
      pm_rst_r <= 1'b0;
      gm_r <= OSC_GM_RESET;
      cap_r <= OSC_CAP_RESET;
      pin_cfg_r <= PIN_CFG_RESET;
      carrier_regs_a_r <= CARRIER_REGS_A_RESET;
      if_r <= IF_RESET;
      loop_r <= LOOP_RESET;
    end else if (wr_fire) begin
      if (aw_a_r == ADDR_PWR) begin
        pm_mode_r <= power_mode_type'(wm[1:0]);
        pm_rst_r <= wm[PM_RST_BIT];
      end else if (aw_a_r == ADDR_OSC) begin
        gm_r <= wm[3:0];
      end else if (aw_a_r == ADDR_CAP) begin
        cap_r <= wm[5:0];
      end else if (aw_a_r == ADDR_PIN) begin
        pin_cfg_r <= wm[7:0];
      end else if (aw_a_r == ADDR_CARRIER_REGS_A) begin
        carrier_regs_a_r <= wm;
      end else if (aw_a_r == ADDR_IF) begin
        if_r <= wm;
      end else if (aw_a_r == ADDR_LOOP) begin
        loop_r <= wm[4:0];
      end
    end
  end

  // ****************************************************************
  // regulator status: live levels and sticky brown-out flags
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (clr) begin
      sticky_r <= 2'h0;
      vprev_r <= 2'h0;
    end else begin
      vprev_r <= regulator_status_reg_level;
      // a fall in the same cycle as a clear still sets the flag
      sticky_r <= (sticky_r & ~({2{wr_fire && aw_a_r == ADDR_REGULATOR_STATUS_REG}} &
                  w_d_r[REGULATOR_STATUS_REG_STK2_BIT:REGULATOR_STATUS_REG_STK1_BIT])) |
                  (vprev_r & ~regulator_status_reg_level);
    end
  end

  // ****************************************************************
  // vco ranging
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (clr) begin
      ranging_start_bit_r <= 1'b0;
      rng_err_r <= 1'b0;
      rng_cnt_r <= 16'h0000;
    end else if (ranging_start_bit_r) begin
      if (rng_cnt_r == RNG_LAST) begin
        ranging_start_bit_r <= 1'b0;
        rng_err_r <= ~vco_in_range;
      end else begin
        rng_cnt_r <= rng_cnt_r + 16'h0001;
      end
    end else if (wr_fire && aw_a_r == ADDR_RNG && wm[RANGING_START_BIT_BIT]) begin
      ranging_start_bit_r <= 1'b1;
      rng_err_r <= 1'b0;
      rng_cnt_r <= 16'h0000;
    end
  end

  // ****************************************************************
  // reference clock divider, ratio 2**sel, sel above 11 clamps
  // ****************************************************************
  assign clk_en = ~pin_cfg_r[PIN_DIS_BIT];
  assign sel_change = pin_cfg_r[3:0] != sel_prev_r;
  assign div_last = (pin_cfg_r[3:0] >= DIV_MAX_SEL) ? 10'h3FF :
    10'((11'h001 << (pin_cfg_r[3:0] - 4'h1)) - 11'h001);

  always_ff @(posedge aclk) begin
    if (clr) begin
      div_cnt_r <= 10'h000;
      div_out_r <= 1'b0;
      sel_prev_r <= PIN_CFG_RESET[3:0];
      ratio_one_r <= 1'b0;
    end else begin
      sel_prev_r <= pin_cfg_r[3:0];
      ratio_one_r <= clk_en && pin_cfg_r[3:0] == 4'h0;
      if (!clk_en || sel_change || pin_cfg_r[3:0] == 4'h0) begin
        div_cnt_r <= 10'h000;
        div_out_r <= 1'b0;
      end else if (div_cnt_r == div_last) begin
        div_cnt_r <= 10'h000;
        div_out_r <= ~div_out_r;
      end else begin
        div_cnt_r <= div_cnt_r + 10'h001;
      end
    end
  end

  // ratio one passes the reference itself; no flop can toggle that fast
  assign divided_ref_clock_out = ratio_one_r ? aclk : div_out_r;

  // ****************************************************************
  // operating mode sequencing
  // ****************************************************************
  assign rx_sel = pm_mode_r == PM_RX;
  assign tx_sel = pm_mode_r == PM_TX;

  always_comb begin
    op_nxt = op_r;
    case (op_r)
      OP_IDLE: begin
        if (rx_sel || tx_sel) begin
          op_nxt = OP_REG_UP;
        end
      end
      OP_REG_UP: begin
        if (!(rx_sel || tx_sel)) begin
          op_nxt = OP_IDLE;
        end else if (regulator_status_reg_level.above_2v3) begin
          op_nxt = OP_RUN;
        end
      end
      default: begin
        if (!(rx_sel || tx_sel)) begin
          op_nxt = OP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (clr) begin
      op_r <= OP_IDLE;
      regulator_on_r <= 1'b0;
      osc_enable_r <= 1'b0;
      rx_enable_r <= 1'b0;
      tx_enable_r <= 1'b0;
      synth_carrier_regs_a_r <= CARRIER_REGS_A_RESET;
    end else begin
      op_r <= op_nxt;
      regulator_on_r <= rx_sel || tx_sel;
      osc_enable_r <= pm_mode_r != PM_DOWN;
      rx_enable_r <= op_nxt == OP_RUN && rx_sel;
      tx_enable_r <= op_nxt == OP_RUN && tx_sel;
      synth_carrier_regs_a_r <= (op_nxt == OP_RUN && rx_sel) ? carrier_regs_a_r - if_r :
                      carrier_regs_a_r;
    end
  end

  // ****************************************************************
  // axi4-lite slave; bus state survives soft and pin resets
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_r <= 1'b0;
      w_v_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_a_r <= 8'h00;
      w_d_r <= 32'h0000_0000;
      w_s_r <= 4'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      if (awvalid && awready_r) begin
        aw_v_r <= 1'b1;
        awready_r <= 1'b0;
        aw_a_r <= awaddr;
      end
      if (wvalid && wready_r) begin
        w_v_r <= 1'b1;
        wready_r <= 1'b0;
        w_d_r <= wdata;
        w_s_r <= wstrb;
      end
      if (wr_fire) begin
        aw_v_r <= 1'b0;
        w_v_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
        bvalid_r <= 1'b1;
        bresp_r <= word_at(aw_a_r) >> 32 != 33'h0 ? RESP_OKAY :
                   RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= 32'(word_at(araddr));
        rresp_r <= word_at(araddr) >> 32 != 33'h0 ? RESP_OKAY :
                   RESP_SLVERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign regulator_on = regulator_on_r;
  assign osc_enable = osc_enable_r;
  assign rx_enable = rx_enable_r;
  assign tx_enable = tx_enable_r;
  assign ranging_active = ranging_start_bit_r;
  assign synth_carrier_regs_a_hz = synth_carrier_regs_a_r;
  assign osc_transconductance = gm_r;
  assign osc_tuning_cap = cap_r;
  assign band_select_bit = loop_r[BAND_BIT];
  assign synth_loop_bits = loop_r[3:0];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_div_toggle;
    clk_en && !sel_change && !clr && pin_cfg_r[3:0] != 4'h0 &&
      div_cnt_r == div_last |=> div_out_r != $past(div_out_r);
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("divider missed its half-period toggle");
  property p_div_off;
    !clk_en |=> !div_out_r && div_cnt_r == 10'h000;
  endproperty
  a_div_off: assert property (p_div_off)
    else $error("clock output active while disabled");
  property p_restart;
    sel_change && !clr |=> div_cnt_r == 10'h000 && !div_out_r;
  endproperty
  a_restart: assert property (p_restart)
    else $error("divider did not restart on ratio change");
  property p_soft;
    soft_rst_r |=> pm_mode_r == PM_DOWN && !pm_rst_r && !regulator_on_r;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset left state behind");
  property p_pin_ign;
    !por_done_r |-> !clr;
  endproperty
  a_pin_ign: assert property (p_pin_ign)
    else $error("reset pin honoured before power-on completed");
  property p_defaults;
    pin_rst |=> if_r == IF_RESET && pin_cfg_r == PIN_CFG_RESET &&
      !osc_enable_r;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("pin reset did not restore defaults");
  property p_reg_first;
    (rx_enable_r || tx_enable_r) |-> regulator_on_r &&
      $past(regulator_status_reg_level.above_2v3) || $past(op_r) == OP_RUN;
  endproperty
  a_reg_first: assert property (p_reg_first)
    else $error("operation started before regulator came up");
  property p_sticky;
    !clr && $past(regulator_status_reg_level.above_1v3) && !regulator_status_reg_level.above_1v3
      |=> sticky_r[0] [*2];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("brown-out flag not held");
  property p_if_shift;
    rx_enable_r |-> synth_carrier_regs_a_r == $past(carrier_regs_a_r) - $past(if_r);
  endproperty
  a_if_shift: assert property (p_if_shift)
    else $error("receive frequency not offset by IF");
  property p_rng_end;
    $rose(ranging_start_bit_r) |-> ##[1:300] !ranging_start_bit_r;
  endproperty
  a_rng_end: assert property (p_rng_end)
    else $error("ranging never finished");

  c_rx_run: cover property (rx_enable_r);
  c_rng_err: cover property ($fell(ranging_start_bit_r) ##1 rng_err_r);
  c_soft: cover property (soft_rst_r);
  c_pin: cover property ($fell(pin_rst));
endmodule

// >>> prcc_pkg.sv
// constants, types and register map of the power, reset and clock block
package prcc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) /
                              CLK_PERIOD_NS;
  localparam int RANGING_TIME_NS = 2000;
  localparam int RNG_CYCLES = (RANGING_TIME_NS + CLK_PERIOD_NS - 1) /
                              CLK_PERIOD_NS;
  localparam logic [15:0] POR_LAST = 16'(POR_CYCLES - 1);
  localparam logic [15:0] RNG_LAST = 16'(RNG_CYCLES - 1);

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_PWR = 8'h00;
  localparam logic [7:0] ADDR_REGULATOR_STATUS_REG = 8'h04;
  localparam logic [7:0] ADDR_OSC = 8'h08;
  localparam logic [7:0] ADDR_CAP = 8'h0C;
  localparam logic [7:0] ADDR_PIN = 8'h10;
  localparam logic [7:0] ADDR_CARRIER_REGS_A = 8'h14;
  localparam logic [7:0] ADDR_IF = 8'h18;
  localparam logic [7:0] ADDR_LOOP = 8'h1C;
  localparam logic [7:0] ADDR_RNG = 8'h20;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int PM_RST_BIT = 7;
  localparam int REGULATOR_STATUS_REG_STK1_BIT = 2;
  localparam int REGULATOR_STATUS_REG_STK2_BIT = 3;
  localparam int PIN_DIS_BIT = 4;
  localparam int RANGING_START_BIT_BIT = 4;
  localparam int RNG_ERR_BIT = 5;
  localparam int BAND_BIT = 4;
  localparam logic [3:0] OSC_GM_RESET = 4'h8;
  localparam logic [5:0] OSC_CAP_RESET = 6'h00;
  localparam logic [7:0] PIN_CFG_RESET = 8'h05;
  localparam logic [31:0] CARRIER_REGS_A_RESET = 32'h0000_0000;
  localparam logic [31:0] IF_RESET = 32'h000F_4240;
  localparam logic [4:0] LOOP_RESET = 5'h00;
  localparam logic [3:0] DIV_MAX_SEL = 4'hB;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {PM_DOWN, PM_STANDBY, PM_RX, PM_TX}
    power_mode_type;
  typedef enum logic [1:0] {OP_IDLE, OP_REG_UP, OP_RUN} op_state_type;
  typedef struct packed {
    logic above_2v3;
    logic above_1v3;
  } regulator_status_reg_level_type;

endpackage

// >>> testbench.sv
// register-level testbench of the power, reset and clock block
`timescale 1ns/1ns
module testbench;
  import prcc_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, synth_carrier_regs_a_hz, d;
  logic [3:0] wstrb, osc_transconductance, synth_loop_bits;
  logic [1:0] bresp, rresp, r, last_bresp;
  logic awready, wready, bvalid, arready, rvalid, reset_pin_n;
  logic divided_ref_clock_out, regulator_on, osc_enable, rx_enable;
  logic tx_enable, ranging_active, band_select_bit, vco_in_range;
  logic brown, vco_ok;
  logic [5:0] osc_tuning_cap;
  regulator_status_reg_level_type regulator_status_reg_level;
  int errors, n_checks, cyc, hi, lo;
  logic [7:0] ra [8];
  logic [31:0] rv [8];
  int sel_v [5] = '{1, 2, 5, 11, 15};
  int half_v [5] = '{1, 2, 16, 1024, 1024};

  power_reset_clock_control dut_u (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .reset_pin_n(reset_pin_n),
    .regulator_status_reg_level(regulator_status_reg_level), .vco_in_range(vco_in_range),
    .divided_ref_clock_out(divided_ref_clock_out),
    .regulator_on(regulator_on), .osc_enable(osc_enable),
    .rx_enable(rx_enable), .tx_enable(tx_enable),
    .ranging_active(ranging_active), .synth_carrier_regs_a_hz(synth_carrier_regs_a_hz),
    .osc_transconductance(osc_transconductance),
    .osc_tuning_cap(osc_tuning_cap), .band_select_bit(band_select_bit),
    .synth_loop_bits(synth_loop_bits));

  analog_env_model env_u (.aclk(aclk), .regulator_on(regulator_on),
    .brown(brown), .vco_ok(vco_ok), .regulator_status_reg_level(regulator_status_reg_level),
    .vco_in_range(vco_in_range));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // readys are looked at mid-cycle, where they stand for the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, ad, wd;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      if (ah) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wh) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    ah = 1'b0;
    while (!ah) begin
      @(negedge aclk);
      ah = bvalid;
      last_bresp = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hs = 1'b0;
    while (!hs) begin
      @(negedge aclk);
      hs = arvalid && arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs) begin
      @(negedge aclk);
      hs = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(d, exp);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  // measures one high and one low phase of the divided clock
  task automatic div(input logic [31:0] cfg);
    wr(ADDR_PIN, cfg);
    do @(negedge aclk); while (divided_ref_clock_out !== 1'b0);
    do @(negedge aclk); while (divided_ref_clock_out !== 1'b1);
    hi = 0;
    lo = 0;
    while (divided_ref_clock_out === 1'b1) begin
      hi++;
      @(negedge aclk);
    end
    while (divided_ref_clock_out === 1'b0) begin
      lo++;
      @(negedge aclk);
    end
  endtask

  // ****************************************************************
  // clock, timeout and test sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, brown} = '0;
    wstrb = 4'hF;
    reset_pin_n = 1'b1;
    vco_ok = 1'b1;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    ra = '{ADDR_PWR, ADDR_REGULATOR_STATUS_REG, ADDR_OSC, ADDR_CAP, ADDR_PIN, ADDR_CARRIER_REGS_A,
           ADDR_IF, ADDR_LOOP};
    rv = '{32'h0000_0000, 32'h0000_0001, 32'(OSC_GM_RESET),
           32'(OSC_CAP_RESET), 32'(PIN_CFG_RESET), CARRIER_REGS_A_RESET, IF_RESET,
           32'(LOOP_RESET)};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(ra[i], rv[i]);
    chk(32'({regulator_on, osc_enable}), 32'h0000_0000);
    // a pin pulse before power-on completes must leave settings alone
    wr(ADDR_CAP, 32'h0000_0015);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    reset_pin_n <= 1'b1;
    rchk(ADDR_CAP, 32'h0000_0015);
    rd(8'h40, d, r);
    chk({d[29:0], r}, 32'(RESP_SLVERR));
    wr(8'h44, 32'h0000_00FF);
    chk(32'(last_bresp), 32'(RESP_SLVERR));
    wr(ADDR_OSC, 32'h0000_0003);
    wr(ADDR_CAP, 32'h0000_002A);
    wr(ADDR_LOOP, 32'h0000_0019);
    @(negedge aclk);
    chk(32'({osc_transconductance, osc_tuning_cap}),
        32'h0000_00EA);
    chk(32'({band_select_bit, synth_loop_bits}), 32'h0000_0019);
    wr(ADDR_PWR, 32'h0000_0001);
    @(negedge aclk);
    chk(32'({osc_enable, regulator_on}), 32'h0000_0002);
    wr(ADDR_CARRIER_REGS_A, 32'h33BC_A101);
    wr(ADDR_PWR, 32'h0000_0002);
    repeat (10) @(negedge aclk);
    chk(32'({regulator_on, rx_enable}), 32'h0000_0003);
    chk(synth_carrier_regs_a_hz, 32'h33BC_A101 - IF_RESET);
    // brown-out while powered: sticky copies outlive the dip
    @(posedge aclk);
    brown <= 1'b1;
    repeat (3) @(posedge aclk);
    rchk(ADDR_REGULATOR_STATUS_REG, 32'h0000_000C);
    brown <= 1'b0;
    repeat (6) @(posedge aclk);
    rchk(ADDR_REGULATOR_STATUS_REG, 32'h0000_000F);
    wr(ADDR_REGULATOR_STATUS_REG, 32'h0000_000C);
    rchk(ADDR_REGULATOR_STATUS_REG, 32'h0000_0003);
    wr(ADDR_PWR, 32'h0000_0003);
    repeat (4) @(negedge aclk);
    chk(32'({tx_enable, rx_enable}), 32'h0000_0002);
    chk(synth_carrier_regs_a_hz, 32'h33BC_A101);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      vco_ok <= (i == 0);
      wr(ADDR_RNG, 32'h0000_0010);
      rchk(ADDR_RNG, 32'h0000_0010);
      chk(32'(ranging_active), 32'h0000_0001);
      repeat (RNG_CYCLES + 10) @(posedge aclk);
      rchk(ADDR_RNG, (i == 0) ? 32'h0000_0000 : 32'h0000_0020);
    end
    // power-of-two ratios: high phase is half the period, low phase equal to it
    for (int i = 0; i < 5; i++) begin
      div(32'(sel_v[i]));
      chk(32'(hi), 32'(half_v[i]));
      chk(32'(lo), 32'(hi));
    end
    // ratio one passes the reference: high just after a rising edge
    wr(ADDR_PIN, 32'h0000_0000);
    @(negedge aclk);
    #6;
    chk(32'(divided_ref_clock_out), 32'h0000_0001);
    wr(ADDR_PIN, 32'h0000_0013);
    hi = 0;
    repeat (40) begin
      @(negedge aclk);
      hi += int'(divided_ref_clock_out !== 1'b0);
    end
    chk(32'(hi), 32'h0000_0000);
    wr(ADDR_PWR, 32'h0000_0080);
    wr(ADDR_PWR, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    for (int i = 2; i < 8; i++) rchk(ra[i], rv[i]);
    wr(ADDR_CAP, 32'h0000_0011);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge aclk);
    reset_pin_n <= 1'b1;
    rchk(ADDR_CAP, 32'(OSC_CAP_RESET));
    @(negedge aclk);
    chk(32'({osc_enable, regulator_on}), 32'h0000_0000);
    test_done();
  end
endmodule
